// ---- hdl/dead_band_gen.sv ----
// complementary pair with rising and falling dead band
`timescale 1ns/1ps
module dead_band_gen (
    // clock and reset
    input wire logic clk,
    input wire logic rstN,
    // pair control and outputs
    dead_band_if.gen db
);
    logic hi_q;
    logic lo_q;
    logic last_q;
    logic [pwm_out_pkg::DB_W-1:0] cnt_q;
    logic [pwm_out_pkg::DB_W-1:0] lim;
    logic [pwm_out_pkg::DB_W-1:0] offCnt_q;

    assign lim = db.drive ? db.riseCnt : db.fallCnt;
    assign db.hi = hi_q;
    assign db.lo = lo_q;

    // both off on a change, new side after lim cycles
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            hi_q <= 1'b0;
            lo_q <= 1'b0;
            last_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (!db.enable) begin
            hi_q <= 1'b0;
            lo_q <= 1'b0;
            last_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (db.drive != last_q) begin
            // a change always restarts the gap count from one
            last_q <= db.drive;
            hi_q <= db.drive && lim == 8'h00;
            lo_q <= !db.drive && lim == 8'h00;
            cnt_q <= 8'h01;
        end else if (!(hi_q || lo_q)) begin
            hi_q <= db.drive && cnt_q >= lim;
            lo_q <= !db.drive && cnt_q >= lim;
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // helper: cycles both outputs have been off
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            offCnt_q <= 8'h00;
        end else if (hi_q || lo_q) begin
            offCnt_q <= 8'h00;
        end else if (offCnt_q != 8'hff) begin
            offCnt_q <= offCnt_q + 8'h01;
        end
    end

    a_db_no_overlap: assert property (@(posedge clk) disable iff (!rstN)
        !(hi_q && lo_q)) else $error("pair outputs overlap");
    a_db_rise_gap: assert property (@(posedge clk) disable iff (!rstN)
        $rose(hi_q) && $past(lo_q) == 1'b0 && $past(db.enable) |->
        {1'b0, $past(offCnt_q)} + 9'h001 >= {1'b0, $past(db.riseCnt)}
    ) else $error("rising dead band too short");
endmodule // dead_band_gen

// ---- hdl/pwm_base_latch.sv ----
// base waveform latch, cycle phase, fixed-duty toggle, fractional adjust
`timescale 1ns/1ps
module pwm_base_latch (
    // clock and reset
    input wire logic clk,
    input wire logic rstN,
    // events
    input wire logic riseEvt,
    input wire logic fallEvt,
    input wire logic periodEvt,
    // fractional adjust
    input wire logic fracEn,
    input wire logic [pwm_out_pkg::FRAC_W-1:0] fracStep,
    // results
    output logic latchQ,
    output logic phaseQ,
    output logic toggleQ,
    output logic stretchQ
);
    logic [pwm_out_pkg::FRAC_W:0] fracSum;
    logic [pwm_out_pkg::FRAC_W-1:0] fracAcc_q;

    assign fracSum = {1'b0, fracAcc_q} + {1'b0, fracStep};

    // sr latch: falling wins so equal events give zero duty
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            latchQ <= 1'b0;
        end else if (fallEvt) begin
            latchQ <= 1'b0;
        end else if (riseEvt) begin
            latchQ <= 1'b1;
        end
    end

    // even/odd cycle and fixed-duty toggle
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            phaseQ <= 1'b0;
            toggleQ <= 1'b0;
        end else if (periodEvt) begin
            phaseQ <= !phaseQ;
            toggleQ <= !toggleQ;
        end
    end

    // accumulator overflow asks for a one-count longer period
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            fracAcc_q <= 16'h0000;
            stretchQ <= 1'b0;
        end else begin
            stretchQ <= fracEn && periodEvt && fracSum[pwm_out_pkg::FRAC_W];
            if (fracEn && periodEvt) begin
                fracAcc_q <= fracSum[pwm_out_pkg::FRAC_W-1:0];
            end
        end
    end

    a_latch_clear: assert property (@(posedge clk) disable iff (!rstN)
        fallEvt |=> !latchQ) else $error("latch not cleared");
    a_latch_set: assert property (@(posedge clk) disable iff (!rstN)
        riseEvt && !fallEvt |=> latchQ) else $error("latch not set");
    a_phase_flip: assert property (@(posedge clk) disable iff (!rstN)
        periodEvt |=> phaseQ != $past(phaseQ)) else $error("no flip");
endmodule // pwm_base_latch

// ---- hdl/pwm_output_stage.sv ----
// twelve-mode pwm output stage with apb register access
`timescale 1ns/1ps
module pwm_output_stage (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwm_out_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // waveform events from the timing logic
    input wire logic riseEvt,
    input wire logic fallEvt,
    input wire logic periodEvt,
    // period stretch request and output pins a..f
    output logic fracStretch,
    output logic [pwm_out_pkg::NUM_PINS-1:0] pwmOut
);
    localparam int NP = pwm_out_pkg::NUM_PINS;
    localparam int NPAIR = 3;

    logic rstMeta_q;
    logic rstN;
    logic [pwm_out_pkg::MODE_W-1:0] mode_q;
    logic enable_q;
    logic reverse_q;
    logic [NP-1:0] steer_q;
    logic [pwm_out_pkg::DB_W-1:0] dbRise_q;
    logic [pwm_out_pkg::DB_W-1:0] dbFall_q;
    logic [pwm_out_pkg::FRAC_W-1:0] frac_q;
    logic [31:0] prdata_q;
    logic [NP-1:0] pins_q;
    logic [NP-1:0] pins_d;
    logic revEff_q;
    logic [pwm_out_pkg::DB_W-1:0] chgCnt_q;
    logic changing;
    logic latchQ;
    logic phaseQ;
    logic toggleQ;
    logic mapped;
    logic setup;
    logic wrAcc;
    logic fixedMode;
    logic [NPAIR-1:0] pairDrive;
    logic [NPAIR-1:0] pairEn;
    logic [NPAIR-1:0] pairHi;
    logic [NPAIR-1:0] pairLo;
    pwm_out_pkg::mode_t modeSel;

    // reset release through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_q <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstN <= rstMeta_q;
        end
    end

    // apb decode: zero wait states, error on unmapped words
    assign setup = psel && !penable;
    assign wrAcc = psel && penable && pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;

    always_comb begin
        unique case (paddr)
            pwm_out_pkg::OFS_CTRL,
            pwm_out_pkg::OFS_STEER,
            pwm_out_pkg::OFS_DB_RISE,
            pwm_out_pkg::OFS_DB_FALL,
            pwm_out_pkg::OFS_FRAC: mapped = 1'b1;
            pwm_out_pkg::OFS_STATUS: mapped = !pwrite;
            default: mapped = 1'b0;
        endcase
    end

    // register writes
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            mode_q <= pwm_out_pkg::MODE_RST;
            enable_q <= 1'b0;
            reverse_q <= 1'b0;
            steer_q <= pwm_out_pkg::STEER_RST;
            dbRise_q <= pwm_out_pkg::DB_RST;
            dbFall_q <= pwm_out_pkg::DB_RST;
            frac_q <= pwm_out_pkg::FRAC_RST;
        end else if (wrAcc) begin
            unique case (paddr)
                pwm_out_pkg::OFS_CTRL: begin
                    mode_q <= pwdata[pwm_out_pkg::CTRL_MODE_LSB +: 4];
                    enable_q <= pwdata[pwm_out_pkg::CTRL_EN_BIT];
                    reverse_q <= pwdata[pwm_out_pkg::CTRL_REV_BIT];
                end
                pwm_out_pkg::OFS_STEER: steer_q <= pwdata[NP-1:0];
                pwm_out_pkg::OFS_DB_RISE: dbRise_q <= pwdata[7:0];
                pwm_out_pkg::OFS_DB_FALL: dbFall_q <= pwdata[7:0];
                pwm_out_pkg::OFS_FRAC: frac_q <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= 32'h0000_0000;
            unique case (paddr)
                pwm_out_pkg::OFS_CTRL:
                    prdata_q[5:0] <= {reverse_q, enable_q, mode_q};
                pwm_out_pkg::OFS_STEER: prdata_q[NP-1:0] <= steer_q;
                pwm_out_pkg::OFS_DB_RISE: prdata_q[7:0] <= dbRise_q;
                pwm_out_pkg::OFS_DB_FALL: prdata_q[7:0] <= dbFall_q;
                pwm_out_pkg::OFS_FRAC: prdata_q[15:0] <= frac_q;
                pwm_out_pkg::OFS_STATUS: begin
                    prdata_q[pwm_out_pkg::ST_LATCH_BIT] <= latchQ;
                    prdata_q[pwm_out_pkg::ST_PHASE_BIT] <= phaseQ;
                    prdata_q[pwm_out_pkg::ST_TOGGLE_BIT] <= toggleQ;
                    prdata_q[pwm_out_pkg::ST_CHANGE_BIT] <= changing;
                    prdata_q[pwm_out_pkg::ST_PINS_LSB +: NP] <= pins_q;
                end
                default: ;
            endcase
        end
    end

    assign modeSel = pwm_out_pkg::mode_t'(mode_q);
    assign fixedMode = modeSel == pwm_out_pkg::MODE_FIXED_DUTY ||
        modeSel == pwm_out_pkg::MODE_FIXED_DUTY_COMPL;

    // base waveform and per-period state
    pwm_base_latch baseLatch (
        .clk(clk),
        .rstN(rstN),
        .riseEvt(riseEvt),
        .fallEvt(fallEvt),
        .periodEvt(periodEvt),
        .fracEn(enable_q && fixedMode),
        .fracStep(frac_q),
        .latchQ(latchQ),
        .phaseQ(phaseQ),
        .toggleQ(toggleQ),
        .stretchQ(fracStretch)
    );

    // legacy bridge: all off while the new direction waits out dead band
    assign changing = reverse_q != revEff_q;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            revEff_q <= 1'b0;
            chgCnt_q <= 8'h00;
        end else if (!changing) begin
            chgCnt_q <= 8'h00;
        end else if (chgCnt_q >= (reverse_q ? dbRise_q : dbFall_q)) begin
            revEff_q <= reverse_q;
            chgCnt_q <= 8'h00;
        end else begin
            chgCnt_q <= chgCnt_q + 8'h01;
        end
    end

    // what each dead-band pair is fed, per mode
    always_comb begin
        pairDrive = '0;
        pairEn = '0;
        if (enable_q) begin
            unique case (modeSel)
                pwm_out_pkg::MODE_COMPL: begin
                    pairDrive = {NPAIR{latchQ}};
                    pairEn = '1;
                end
                pwm_out_pkg::MODE_PP_COMPL: begin
                    pairDrive = {latchQ && phaseQ, 1'b0,
                        latchQ && !phaseQ};
                    pairEn = 3'b101;
                end
                pwm_out_pkg::MODE_PP_BRIDGE_COMPL: begin
                    pairDrive = {1'b0, latchQ && phaseQ,
                        latchQ && !phaseQ};
                    pairEn = 3'b011;
                end
                pwm_out_pkg::MODE_SKIP_COMPL: begin
                    pairDrive = {2'b00, latchQ};
                    pairEn = 3'b001;
                end
                pwm_out_pkg::MODE_FIXED_DUTY_COMPL: begin
                    pairDrive = {NPAIR{toggleQ}};
                    pairEn = '1;
                end
                default: ; // no dead-band pair in other modes
            endcase
        end
    end

    // one dead-band generator per output pair
    dead_band_if dbIf[NPAIR] ();
    for (genvar g = 0; g < NPAIR; g++) begin : gPair
        assign dbIf[g].enable = pairEn[g];
        assign dbIf[g].drive = pairDrive[g];
        assign dbIf[g].riseCnt = dbRise_q;
        assign dbIf[g].fallCnt = dbFall_q;
        assign pairHi[g] = dbIf[g].hi;
        assign pairLo[g] = dbIf[g].lo;
        dead_band_gen dbGen (
            .clk(clk),
            .rstN(rstN),
            .db(dbIf[g])
        );
    end

    // pin map per mode; unused pins stay low
    always_comb begin
        pins_d = '0;
        if (enable_q) begin
            unique case (modeSel)
                pwm_out_pkg::MODE_SINGLE:
                    pins_d = steer_q & {NP{latchQ}};
                pwm_out_pkg::MODE_COMPL: begin
                    pins_d[pwm_out_pkg::PIN_A] = pairHi[0];
                    pins_d[pwm_out_pkg::PIN_B] = pairLo[0];
                    pins_d[pwm_out_pkg::PIN_C] = pairHi[1];
                    pins_d[pwm_out_pkg::PIN_D] = pairLo[1];
                    pins_d[pwm_out_pkg::PIN_E] = pairHi[2];
                    pins_d[pwm_out_pkg::PIN_F] = pairLo[2];
                    pins_d = pins_d & steer_q;
                end
                pwm_out_pkg::MODE_PUSH_PULL: begin
                    pins_d[pwm_out_pkg::PIN_A] = latchQ && !phaseQ;
                    pins_d[pwm_out_pkg::PIN_B] = latchQ && phaseQ;
                end
                pwm_out_pkg::MODE_PP_COMPL: begin
                    pins_d[pwm_out_pkg::PIN_A] = pairHi[0];
                    pins_d[pwm_out_pkg::PIN_B] = pairLo[0];
                    pins_d[pwm_out_pkg::PIN_E] = pairHi[2];
                    pins_d[pwm_out_pkg::PIN_F] = pairLo[2];
                end
                pwm_out_pkg::MODE_PP_BRIDGE: begin
                    pins_d[pwm_out_pkg::PIN_A] = latchQ && !phaseQ;
                    pins_d[pwm_out_pkg::PIN_D] = latchQ && !phaseQ;
                    pins_d[pwm_out_pkg::PIN_B] = latchQ && phaseQ;
                    pins_d[pwm_out_pkg::PIN_C] = latchQ && phaseQ;
                end
                pwm_out_pkg::MODE_PP_BRIDGE_COMPL: begin
                    pins_d[pwm_out_pkg::PIN_A] = pairHi[0];
                    pins_d[pwm_out_pkg::PIN_D] = pairHi[0];
                    pins_d[pwm_out_pkg::PIN_B] = pairHi[1];
                    pins_d[pwm_out_pkg::PIN_C] = pairHi[1];
                    pins_d[pwm_out_pkg::PIN_E] = pairLo[0];
                    pins_d[pwm_out_pkg::PIN_F] = pairLo[1];
                end
                pwm_out_pkg::MODE_SKIP:
                    pins_d[pwm_out_pkg::PIN_A] = latchQ;
                pwm_out_pkg::MODE_SKIP_COMPL: begin
                    pins_d[pwm_out_pkg::PIN_A] = pairHi[0];
                    pins_d[pwm_out_pkg::PIN_B] = pairLo[0];
                end
                pwm_out_pkg::MODE_LEGACY_BRIDGE: begin
                    if (!changing && !revEff_q) begin
                        pins_d[pwm_out_pkg::PIN_A] = 1'b1;
                        pins_d[pwm_out_pkg::PIN_D] = latchQ;
                    end else if (!changing) begin
                        pins_d[pwm_out_pkg::PIN_C] = 1'b1;
                        pins_d[pwm_out_pkg::PIN_B] = latchQ;
                    end
                end
                pwm_out_pkg::MODE_FIXED_DUTY:
                    pins_d[pwm_out_pkg::PIN_A] = toggleQ;
                pwm_out_pkg::MODE_FIXED_DUTY_COMPL: begin
                    pins_d[pwm_out_pkg::PIN_A] = pairHi[0];
                    pins_d[pwm_out_pkg::PIN_B] = pairLo[0];
                    pins_d[pwm_out_pkg::PIN_C] = pairHi[1];
                    pins_d[pwm_out_pkg::PIN_D] = pairLo[1];
                    pins_d[pwm_out_pkg::PIN_E] = pairHi[2];
                    pins_d[pwm_out_pkg::PIN_F] = pairLo[2];
                end
                pwm_out_pkg::MODE_THREE_PHASE: begin
                    // steering index picks the high/low pair
                    unique case (steer_q[2:0])
                        3'h0: pins_d = 6'h09 & {NP{latchQ}};
                        3'h1: pins_d = 6'h21 & {NP{latchQ}};
                        3'h2: pins_d = 6'h24 & {NP{latchQ}};
                        3'h3: pins_d = 6'h06 & {NP{latchQ}};
                        3'h4: pins_d = 6'h12 & {NP{latchQ}};
                        3'h5: pins_d = 6'h18 & {NP{latchQ}};
                        default: pins_d = '0;
                    endcase
                end
                default: pins_d = '0; // codes 12..15 drive nothing
            endcase
        end
    end

    // registered pins
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pins_q <= '0;
        end else begin
            pins_q <= pins_d;
        end
    end
    assign pwmOut = pins_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    a_off_when_idle: assert property (!enable_q |=> pins_q == '0)
        else $error("pins active while disabled");
    a_single_steer: assert property (
        enable_q && modeSel == pwm_out_pkg::MODE_SINGLE |=>
        pins_q == ($past(steer_q) & {NP{$past(latchQ)}}))
        else $error("single-phase pins wrong");
    a_pp_alternate: assert property (
        enable_q && modeSel == pwm_out_pkg::MODE_PUSH_PULL |=>
        pins_q[5:2] == 4'h0 && !(pins_q[0] && pins_q[1]))
        else $error("push-pull pins wrong");
    a_bridge_pins: assert property (
        modeSel == pwm_out_pkg::MODE_PP_BRIDGE |=> pins_q[5:4] == 2'b00)
        else $error("bridge uses e or f");
    a_skip_one_pin: assert property (
        modeSel == pwm_out_pkg::MODE_SKIP |=> pins_q[5:1] == 5'h00)
        else $error("skip mode uses extra pins");
    a_compl_pair_apart: assert property (
        modeSel == pwm_out_pkg::MODE_COMPL |=>
        !(pins_q[0] && pins_q[1]) && !(pins_q[4] && pins_q[5]))
        else $error("complementary pair overlaps");
    a_three_phase_two: assert property (
        modeSel == pwm_out_pkg::MODE_THREE_PHASE |=> $countones(pins_q) <= 2)
        else $error("too many three-phase pins");
    a_dir_change_off: assert property (
        changing && modeSel == pwm_out_pkg::MODE_LEGACY_BRIDGE |=>
        pins_q == '0) else $error("bridge drives during change");
    a_fixed_toggle: assert property (
        enable_q && modeSel == pwm_out_pkg::MODE_FIXED_DUTY && periodEvt
        ##1 enable_q |=> pins_q[0] != $past(pins_q[0]))
        else $error("fixed duty did not toggle");

    c_single_pulse: cover property (
        modeSel == pwm_out_pkg::MODE_SINGLE && $rose(pins_q[0]));
    c_compl_run: cover property (
        modeSel == pwm_out_pkg::MODE_COMPL && $rose(pins_q[1]));
    c_dir_change: cover property ($fell(changing) && enable_q);
    c_frac_stretch: cover property (fracStretch);
endmodule // pwm_output_stage

// ---- shared/dead_band_if.sv ----
// signals between the output stage and one dead-band pair generator
`timescale 1ns/1ps
interface dead_band_if;
    logic enable;
    logic drive;
    logic [pwm_out_pkg::DB_W-1:0] riseCnt;
    logic [pwm_out_pkg::DB_W-1:0] fallCnt;
    logic hi;
    logic lo;
    modport gen (input enable, drive, riseCnt, fallCnt, output hi, lo);
    modport user (output enable, drive, riseCnt, fallCnt, input hi, lo);
endinterface

// ---- shared/pwm_out_pkg.sv ----
// constants, register map and mode list of the pwm output stage
package pwm_out_pkg;
    localparam int ADDR_W = 8;
    localparam int NUM_PINS = 6;
    localparam int DB_W = 8;
    localparam int FRAC_W = 16;
    localparam int MODE_W = 4;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STEER = 8'h04;
    localparam logic [7:0] OFS_DB_RISE = 8'h08;
    localparam logic [7:0] OFS_DB_FALL = 8'h0c;
    localparam logic [7:0] OFS_FRAC = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_EN_BIT = 4;
    localparam int CTRL_REV_BIT = 5;
    // status fields
    localparam int ST_LATCH_BIT = 0;
    localparam int ST_PHASE_BIT = 1;
    localparam int ST_TOGGLE_BIT = 2;
    localparam int ST_CHANGE_BIT = 3;
    localparam int ST_PINS_LSB = 8;
    // reset values
    localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
    localparam logic [NUM_PINS-1:0] STEER_RST = 6'h01;
    localparam logic [DB_W-1:0] DB_RST = 8'h00;
    localparam logic [FRAC_W-1:0] FRAC_RST = 16'h0000;
    // pin positions
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;
    localparam int PIN_D = 3;
    localparam int PIN_E = 4;
    localparam int PIN_F = 5;
    typedef enum logic [MODE_W-1:0] {
        MODE_SINGLE, MODE_COMPL, MODE_PUSH_PULL, MODE_PP_COMPL,
        MODE_PP_BRIDGE, MODE_PP_BRIDGE_COMPL, MODE_SKIP, MODE_SKIP_COMPL,
        MODE_LEGACY_BRIDGE, MODE_FIXED_DUTY, MODE_FIXED_DUTY_COMPL,
        MODE_THREE_PHASE
    } mode_t;
endpackage

// ---- verif/gate_driver_model.sv ----
// gate driver model that latches any shoot-through on a pin pair while watch is high
`timescale 1ns/1ps
module gate_driver_model (
    // clock, reset and watch window
    input wire logic clk,
    input wire logic arst_n,
    input wire logic watch,
    // gate pins a..f
    input wire logic [5:0] gate,
    // sticky overlap flag
    output logic shoot
);
    // both switches of a leg on together would short the rail
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shoot <= 1'b0;
        end else if (watch && |(gate[4:0] & gate[5:1] & 5'h15)) begin
            shoot <= 1'b1;
        end
    end
endmodule // gate_driver_model

// ---- verif/multi_mode_pwm_output_stage_bench.sv ----
// self-checking bench of the pwm output stage
`timescale 1ns/1ps
module multi_mode_pwm_output_stage_bench;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
    logic riseEvt, fallEvt, periodEvt, shoot, watch, ph, stretch;
    logic [7:0] paddr, dr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] pwmOut, st;
    int n_mismatch, num_checks, nStretch;
    pwm_output_stage dut_u (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .riseEvt(riseEvt), .fallEvt(fallEvt),
        .periodEvt(periodEvt), .fracStretch(stretch), .pwmOut(pwmOut));
    gate_driver_model drv_u (.clk(clk), .arst_n(arst_n), .watch(watch),
        .gate(pwmOut), .shoot(shoot));
    // expected pins after the latch settles
    function logic [5:0] pins_for(input int m, input logic [5:0] s,
                                  input logic q);
        if (m == 0) return q ? s : 6'h00;
        return (q ? 6'h15 : 6'h2a) & s;
    endfunction
    // three-phase high/low pair for a steering index
    function logic [5:0] tri_pins(input logic [5:0] i);
        case (i)
            6'h00: return 6'h09;
            6'h01: return 6'h21;
            6'h02: return 6'h24;
            6'h03: return 6'h06;
            6'h04: return 6'h12;
            6'h05: return 6'h18;
            default: return 6'h00;
        endcase
    endfunction
    // count one-cycle period stretch pulses while they stand
    always @(posedge clk) begin
        if (stretch === 1'b1) nStretch++;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // one event pulse (0 rise, 1 fall, 2 period), then settle
    task pulse(input int k);
        riseEvt <= (k == 0);
        fallEvt <= (k == 1);
        periodEvt <= (k == 2);
        @(posedge clk);
        {riseEvt, fallEvt, periodEvt} <= 3'h0;
        repeat (12) @(posedge clk);
    endtask
    task tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // watchdog
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        {arst_n, psel, penable, pwrite, riseEvt, fallEvt} = 6'h00;
        {periodEvt, watch, ph} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rd = $urandom(70863);
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(0, 8'h04, 0);
        check(rd, 32'h1);
        apb(1, 8'h18, 32'h5);
        check(err, 1'b1);
        dr = $urandom_range(1, 5);
        apb(1, 8'h08, dr);
        apb(1, 8'h0c, $urandom_range(1, 5));
        for (int m = 0; m < 2; m++) begin
            apb(1, 8'h00, 32'h10 | m);
            watch <= (m == 1);
            repeat (4) begin
                st = $urandom;
                apb(1, 8'h04, st);
                pulse(0);
                check(pwmOut, pins_for(m, st, 1));
                pulse(1);
                check(pwmOut, pins_for(m, st, 0));
            end
            $display("steered mode %0d done", m);
        end
        // rising dead band: both off until dr cycles after partner off
        apb(1, 8'h04, 32'h3f);
        riseEvt <= 1'b1;
        @(posedge clk);
        riseEvt <= 1'b0;
        repeat (dr + 1) @(posedge clk);
        @(negedge clk);
        check(pwmOut, 6'h00);
        @(negedge clk);
        check(pwmOut, 6'h15);
        @(posedge clk);
        check(shoot, 1'b0);
        watch <= 1'b0;
        apb(1, 8'h00, 32'h12);
        repeat (4) begin
            pulse(2);
            ph = ~ph;
            pulse(0);
            check(pwmOut, ph ? 6'h02 : 6'h01);
            pulse(1);
            check(pwmOut, 6'h00);
        end
        $display("push-pull done");
        apb(1, 8'h00, 32'h19);
        apb(1, 8'h10, 32'h8000);
        pulse(2);
        st = pwmOut;
        pulse(2);
        check(pwmOut, st ^ 6'h01);
        check(nStretch, 1);
        pulse(0);
        check(pwmOut, st ^ 6'h01);
        apb(1, 8'h00, 32'h1c);
        pulse(0);
        check(pwmOut, 6'h00);
        $display("fixed duty and refused mode done");
        apb(1, 8'h00, 32'h16);
        pulse(0);
        check(pwmOut, 6'h01);
        apb(1, 8'h00, 32'h1b);
        repeat (3) begin
            st = $urandom_range(0, 5);
            apb(1, 8'h04, st);
            pulse(0);
            check(pwmOut, tri_pins(st));
        end
        apb(1, 8'h00, 32'h18);
        pulse(0);
        check(pwmOut, 6'h09);
        apb(1, 8'h00, 32'h38);
        pulse(1);
        check(pwmOut, 6'h04);
        $display("skip, three-phase and bridge done");
        tally_and_finish();
    end
endmodule // multi_mode_pwm_output_stage_bench
